// *** design/cpe_cfg.svh ***
// constants for the process data object engine
`ifndef CPE_CFG_SVH
`define CPE_CFG_SVH
`define CPE_SUB_COB      5'h00
`define CPE_SUB_TYPE     5'h01
`define CPE_SUB_INH      5'h02
`define CPE_SUB_COMPAT   5'h03
`define CPE_SUB_EVT      5'h04
`define CPE_SUB_CNT      5'h05
`define CPE_SUB_ENT0     5'h10
`define CPE_SUB_ENTL     5'h1E
`define CPE_SUB_ERR      5'h1F
`define CPE_ERR_STATE    32'h08000022
`define CPE_ERR_OVF      32'h06040042
`define CPE_TT_ACYC      8'h00
`define CPE_TT_SYNC_MAX  8'hF0
`define CPE_TT_RTR_SYNC  8'hFC
`define CPE_TT_RTR_EVT   8'hFD
`define CPE_TT_ASYNC_LO  8'hFE
`define CPE_TT_RESET     8'hFF
`define CPE_VALID_BIT    31
`define CPE_MAX_BITS     9'h040
`define CPE_MAX_CNT      4'hF
`define CPE_NUM_FIXED    4
`define CPE_RX_BASE0     11'h200
`define CPE_RX_BASE1     11'h300
`define CPE_RX_BASE2     11'h400
`define CPE_RX_BASE3     11'h500
`define CPE_TX_BASE0     11'h180
`define CPE_TX_BASE1     11'h280
`define CPE_TX_BASE2     11'h380
`define CPE_TX_BASE3     11'h480
`define CPE_MS_NS        1000000
`define CPE_CLK_NS       8
`endif

// *** design/cpe_pkg.sv ***
// types of the process data object engine
package cpe_pkg;
  typedef logic [14:0][31:0] cpe_ent_type;
  typedef enum logic {cpe_tx_idle, cpe_tx_busy} cpe_txfsm_type;
  typedef struct packed {
    logic [15:0][31:0]  cob;
    logic [15:0][7:0]   ttype;
    logic [15:0][15:0]  inhibit;
    logic [15:0][15:0]  compat;
    logic [15:0][15:0]  evtmr;
    logic [15:0][3:0]   cnt;
    cpe_ent_type [15:0] ent;
    logic [15:0][10:0]  act_id;
    logic               reload;
    logic [31:0]        err;
    logic [31:0]        rdata;
    logic               op_prev;
    logic [16:0]        ms_cnt;
    logic               ms_tick;
    logic [7:0][7:0]    sync_cnt;
    logic [7:0][15:0]   inh_cnt;
    logic [7:0][15:0]   evt_cnt;
    logic [7:0][63:0]   tx_buf;
    logic [7:0][63:0]   last_sent;
    logic [7:0]         evt_pend;
    logic [7:0]         send_pend;
    logic [7:0][63:0]   rx_buf;
    logic [7:0][63:0]   rx_cbuf;
    logic [7:0]         rx_sync_pend;
    logic [7:0]         rx_commit_pend;
    cpe_txfsm_type      tx_fsm;
    logic [2:0]         tx_sel;
    logic               tx_valid;
    logic [10:0]        tx_id;
    logic [3:0]         tx_len;
    logic [63:0]        tx_data;
    logic               commit;
    logic [2:0]         commit_map;
    logic [63:0]        commit_data;
  } cpe_state_type;
endpackage

// *** design/cpe_pdo_engine.sv ***
// process data object engine: eight receive and eight transmit mappings
// What this block does
// R1: frames start only while Operational, one already offered is still held until taken; configuration belongs to Pre-Operational.
// R2: eight mappings per direction, at most eight payload bytes, fewer allowed.
// R3: first four mappings take a fixed identifier; only the valid bit is writable.
// R4: mappings five to eight take a writable identifier and valid bit.
// R5: a written identifier takes effect only after a communication restart.
// R6: fixed receive identifiers are 0x200..0x500 plus node identifier.
// R7: fixed transmit identifiers are 0x180..0x480 plus node identifier.
// R8: receive types 0x00..0xF0 hold payload until the next SYNC.
// R9: receive types 0xFE/0xFF commit at once; 0xF1..0xFD are reserved.
// R10: entry count zero disables the mapping.
// R11: entries hold index, subindex, bit length, packed without gaps.
// R12: transmit event from Operational entry, data change or timer expiry.
// R13: event timer restarts only on its own expiry.
// R14: type zero captures on SYNC and sends on event.
// R15: type n captures and sends on every nth SYNC.
// R16: type 0xFC captures on each SYNC, sends on remote request.
// R17: type 0xFD captures and sends on remote request.
// R18: types 0xFE/0xFF capture and send on event.
// R19: inhibit time in ms spaces sends of asynchronous objects.
// R20: compatibility entry is stored but has no effect.
// R21: event timer period in ms raises a transmit event.
// R22: parameter writes while Operational are rejected with the state code.
// R23: entries exceeding eight bytes are rejected with the overflow code.
// R24: an invalid mapping neither sends nor accepts frames.
`timescale 1ns/1ps
`include "cpe_cfg.svh"
module cpe_pdo_engine #(
  parameter int MS_CYCLES = `CPE_MS_NS / `CPE_CLK_NS
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  input  wire logic [8:0]   addr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [31:0]  rdata_o,
  input  wire logic [6:0]   node_id_i,
  input  wire logic         operational_i,
  input  wire logic         comm_restart_i,
  input  wire logic         sync_i,
  input  wire logic         rx_valid_i,
  input  wire logic [10:0]  rx_id_i,
  input  wire logic         rx_rtr_i,
  input  wire logic [63:0]  rx_data_i,
  input  wire logic [511:0] tx_obj_i,
  output logic              tx_valid_o,
  input  wire logic         tx_ready_i,
  output logic      [10:0]  tx_id_o,
  output logic      [3:0]   tx_len_o,
  output logic      [63:0]  tx_data_o,
  output logic              commit_o,
  output logic      [2:0]   commit_map_o,
  output logic      [63:0]  commit_data_o
);

  cpe_pkg::cpe_state_type st;
  cpe_pkg::cpe_state_type next_st;

  // total mapped bits of the first cnt entries
  function automatic logic [8:0] sum_len(input cpe_pkg::cpe_ent_type e,
                                         input logic [3:0] cnt);
    logic [8:0] s;
    s = '0;
    for (int k = 0; k < 15; k++) begin
      if (4'(k) < cnt) begin
        s = s + {1'b0, e[k][7:0]}; // R11
      end
    end
    return s;
  endfunction

  // mask of the payload bits that the mapping really fills
  function automatic logic [63:0] len_mask(input logic [8:0] bits);
    logic [63:0] m;
    m = '1;
    if (bits < `CPE_MAX_BITS) begin
      m = (64'h0000000000000001 << bits[5:0]) - 64'h0000000000000001;
    end
    return m;
  endfunction

  // identifier of a fixed mapping, from the node identifier
  function automatic logic [10:0] fixed_id(input logic [3:0] i, input logic [6:0] node);
    logic [10:0] b;
    case (i)
      4'h0: b = `CPE_RX_BASE0; // R6
      4'h1: b = `CPE_RX_BASE1;
      4'h2: b = `CPE_RX_BASE2;
      4'h3: b = `CPE_RX_BASE3;
      4'h8: b = `CPE_TX_BASE0; // R7
      4'h9: b = `CPE_TX_BASE1;
      4'hA: b = `CPE_TX_BASE2;
      default: b = `CPE_TX_BASE3;
    endcase
    return b + {4'h0, node};
  endfunction

  // a mapping that may move frames now
  function automatic logic usable(input cpe_pkg::cpe_state_type s, input int i,
                                  input logic op);
    return op && !s.cob[i][`CPE_VALID_BIT] && (s.cnt[i] != 4'h0); // R1 R10 R24
  endfunction

  // next state of everything
  always_comb begin
    logic [4:0]  sub;
    logic [3:0]  ri;
    logic [3:0]  k;
    logic        done;
    logic        evt;
    logic        expire;
    logic        rtr_hit;
    logic [7:0]  t;
    logic [8:0]  bits;
    logic [63:0] now;
    cpe_pkg::cpe_ent_type e;
    sub = addr_i[4:0];
    ri = addr_i[8:5];
    k = 4'h0;
    done = 1'b0;
    evt = 1'b0;
    expire = 1'b0;
    rtr_hit = 1'b0;
    t = 8'h00;
    bits = 9'h000;
    now = '0;
    e = '0;
    next_st = st;
    next_st.rdata = '0;
    next_st.commit = 1'b0;
    next_st.ms_tick = 1'b0;
    next_st.op_prev = operational_i;

    // millisecond time base shared by all timers
    if (st.ms_cnt == 17'(MS_CYCLES - 1)) begin
      next_st.ms_cnt = '0;
      next_st.ms_tick = 1'b1;
    end else begin
      next_st.ms_cnt = st.ms_cnt + 17'h00001;
    end

    // identifiers latch only on restart, so writes never retarget live traffic
    if (st.reload) begin
      for (int i = 0; i < 16; i++) begin
        if ((i % 8) < `CPE_NUM_FIXED) begin
          next_st.act_id[i] = fixed_id(4'(i), node_id_i); // R3 R6 R7
        end else begin
          next_st.act_id[i] = st.cob[i][10:0]; // R4
        end
      end
    end
    next_st.reload = comm_restart_i; // R5

    // register writes; parameters are frozen while Operational
    if (wr_i) begin
      if (sub == `CPE_SUB_ERR) begin
        next_st.err = '0;
      end else if (operational_i) begin
        next_st.err = `CPE_ERR_STATE; // R22
      end else begin
        case (sub)
          `CPE_SUB_COB: begin
            if (ri[2:0] < `CPE_NUM_FIXED) begin
              next_st.cob[ri][`CPE_VALID_BIT] = wdata_i[`CPE_VALID_BIT]; // R3
            end else begin
              next_st.cob[ri] = wdata_i; // R4
            end
          end
          `CPE_SUB_TYPE:   next_st.ttype[ri] = wdata_i[7:0];
          `CPE_SUB_INH:    next_st.inhibit[ri] = wdata_i[15:0];
          `CPE_SUB_COMPAT: next_st.compat[ri] = wdata_i[15:0]; // R20
          `CPE_SUB_EVT:    next_st.evtmr[ri] = wdata_i[15:0];
          `CPE_SUB_CNT: begin
            if (wdata_i[31:4] != 28'h0000000 || wdata_i[3:0] == `CPE_MAX_CNT ||
                sum_len(st.ent[ri], wdata_i[3:0]) > `CPE_MAX_BITS) begin
              next_st.err = `CPE_ERR_OVF; // R23
            end else begin
              next_st.cnt[ri] = wdata_i[3:0]; // R10
            end
          end
          default: begin
            if (sub >= `CPE_SUB_ENT0 && sub <= `CPE_SUB_ENTL) begin
              k = 4'(sub - `CPE_SUB_ENT0);
              e = st.ent[ri];
              e[k] = wdata_i; // R11
              if (sum_len(e, st.cnt[ri]) > `CPE_MAX_BITS) begin
                next_st.err = `CPE_ERR_OVF; // R23
              end else begin
                next_st.ent[ri] = e;
              end
            end
          end
        endcase
      end
    end

    // register reads, answered in the next cycle
    if (rd_i) begin
      case (sub)
        `CPE_SUB_COB: begin
          next_st.rdata = st.cob[ri];
          if (ri[2:0] < `CPE_NUM_FIXED) begin
            next_st.rdata[10:0] = fixed_id(ri, node_id_i);
          end
        end
        `CPE_SUB_TYPE:   next_st.rdata = {24'h000000, st.ttype[ri]};
        `CPE_SUB_INH:    next_st.rdata = {16'h0000, st.inhibit[ri]};
        `CPE_SUB_COMPAT: next_st.rdata = {16'h0000, st.compat[ri]};
        `CPE_SUB_EVT:    next_st.rdata = {16'h0000, st.evtmr[ri]};
        `CPE_SUB_CNT:    next_st.rdata = {28'h0000000, st.cnt[ri]};
        `CPE_SUB_ERR:    next_st.rdata = st.err;
        default: begin
          if (sub >= `CPE_SUB_ENT0 && sub <= `CPE_SUB_ENTL) begin
            next_st.rdata = st.ent[ri][4'(sub - `CPE_SUB_ENT0)];
          end
        end
      endcase
    end

    // receive side: SYNC first, so a frame in the SYNC cycle waits a whole period
    for (int m = 0; m < 8; m++) begin
      if (sync_i && st.rx_sync_pend[m]) begin
        next_st.rx_sync_pend[m] = 1'b0;
        if (usable(st, m, operational_i)) begin
          next_st.rx_cbuf[m] = st.rx_buf[m]; // R8
          next_st.rx_commit_pend[m] = 1'b1;
        end
      end
      if (rx_valid_i && !rx_rtr_i && usable(st, m, operational_i) &&
          rx_id_i == st.act_id[m]) begin // R24
        if (st.ttype[m] <= `CPE_TT_SYNC_MAX) begin
          next_st.rx_buf[m] = rx_data_i; // R8
          next_st.rx_sync_pend[m] = 1'b1;
        end else if (st.ttype[m] >= `CPE_TT_ASYNC_LO) begin
          next_st.rx_cbuf[m] = rx_data_i; // R9
          next_st.rx_commit_pend[m] = 1'b1;
        end
      end
    end
    // one commit per cycle, lowest mapping first; set wins over this clear unless the new payload equals the committed one
    for (int m = 0; m < 8; m++) begin
      if (!done && st.rx_commit_pend[m]) begin
        done = 1'b1;
        next_st.commit = 1'b1;
        next_st.commit_map = 3'(m);
        next_st.commit_data = st.rx_cbuf[m];
        if (!next_st.rx_commit_pend[m] || next_st.rx_cbuf[m] == st.rx_cbuf[m]) begin
          next_st.rx_commit_pend[m] = 1'b0;
        end
      end
    end

    // sender: pick one pending frame, hold it until the controller takes it
    done = 1'b0;
    case (st.tx_fsm)
      cpe_pkg::cpe_tx_idle: begin
        // a frame left pending when Operational drops must not start
        for (int m = 0; m < 8; m++) begin
          if (!done && operational_i && st.send_pend[m]) begin // R1
            done = 1'b1;
            next_st.send_pend[m] = 1'b0;
            next_st.tx_sel = 3'(m);
            next_st.tx_valid = 1'b1;
            next_st.tx_id = st.act_id[8 + m];
            bits = sum_len(st.ent[8 + m], st.cnt[8 + m]);
            next_st.tx_len = 4'((bits + 9'h007) >> 3); // R2
            next_st.tx_data = st.tx_buf[m];
            next_st.last_sent[m] = st.tx_buf[m];
            next_st.tx_fsm = cpe_pkg::cpe_tx_busy;
          end
        end
      end
      cpe_pkg::cpe_tx_busy: begin
        if (tx_ready_i) begin
          next_st.tx_valid = 1'b0;
          next_st.tx_fsm = cpe_pkg::cpe_tx_idle;
          if (st.ttype[8 + st.tx_sel] >= `CPE_TT_ASYNC_LO) begin
            next_st.inh_cnt[st.tx_sel] = st.inhibit[8 + st.tx_sel]; // R19
          end
        end
      end
      default: begin
        next_st.tx_valid = 1'b0;
        next_st.tx_fsm = cpe_pkg::cpe_tx_idle;
      end
    endcase

    // transmit triggers per mapping
    for (int m = 0; m < 8; m++) begin
      t = st.ttype[8 + m];
      bits = sum_len(st.ent[8 + m], st.cnt[8 + m]);
      now = tx_obj_i[m*64 +: 64] & len_mask(bits); // R11
      // free-running event timer, never restarted by other events
      expire = 1'b0;
      if (st.evtmr[8 + m] == 16'h0000) begin
        next_st.evt_cnt[m] = 16'h0000;
      end else if (st.ms_tick) begin
        if (st.evt_cnt[m] + 16'h0001 >= st.evtmr[8 + m]) begin
          next_st.evt_cnt[m] = 16'h0000; // R13
          expire = 1'b1; // R21
        end else begin
          next_st.evt_cnt[m] = st.evt_cnt[m] + 16'h0001;
        end
      end
      if (st.ms_tick && st.inh_cnt[m] != 16'h0000) begin
        next_st.inh_cnt[m] = st.inh_cnt[m] - 16'h0001;
      end
      evt = (operational_i && !st.op_prev) || (now != st.last_sent[m]) || expire; // R12
      rtr_hit = rx_valid_i && rx_rtr_i && rx_id_i == st.act_id[8 + m];
      if (!usable(st, 8 + m, operational_i)) begin
        next_st.evt_pend[m] = 1'b0; // R24
        next_st.send_pend[m] = 1'b0;
        next_st.sync_cnt[m] = 8'h00;
      end else if (t == `CPE_TT_ACYC) begin
        if (sync_i) begin
          next_st.tx_buf[m] = now; // R14
        end
        if (evt) begin
          next_st.send_pend[m] = 1'b1; // R14
        end
      end else if (t <= `CPE_TT_SYNC_MAX) begin
        if (sync_i) begin
          if (st.sync_cnt[m] + 8'h01 >= t) begin
            next_st.sync_cnt[m] = 8'h00;
            next_st.tx_buf[m] = now; // R15
            next_st.send_pend[m] = 1'b1;
          end else begin
            next_st.sync_cnt[m] = st.sync_cnt[m] + 8'h01;
          end
        end
      end else if (t == `CPE_TT_RTR_SYNC) begin
        if (sync_i) begin
          next_st.tx_buf[m] = now; // R16
        end
        if (rtr_hit) begin
          next_st.send_pend[m] = 1'b1; // R16
        end
      end else if (t == `CPE_TT_RTR_EVT) begin
        if (rtr_hit) begin
          next_st.tx_buf[m] = now; // R17
          next_st.send_pend[m] = 1'b1;
        end
      end else if (t >= `CPE_TT_ASYNC_LO) begin
        if (evt) begin
          next_st.evt_pend[m] = 1'b1; // R18
        end
        // inhibit only delays the send; the event stays pending meanwhile
        if (st.evt_pend[m] && st.inh_cnt[m] == 16'h0000 && !st.send_pend[m] &&
            !(st.tx_fsm == cpe_pkg::cpe_tx_busy && st.tx_sel == 3'(m))) begin
          // captured data count as sent, so a stale compare cannot resend them
          next_st.tx_buf[m] = now; // R18
          next_st.send_pend[m] = 1'b1; // R19
          next_st.last_sent[m] = now;
          next_st.evt_pend[m] = 1'b0;
        end
      end
    end
  end

  // state register; clock enable freezes everything except reset, which acts regardless of it
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.reload <= 1'b1;
      st.tx_fsm <= cpe_pkg::cpe_tx_idle;
      for (int i = 0; i < 16; i++) begin
        st.ttype[i] <= `CPE_TT_RESET;
        if ((i % 8) >= `CPE_NUM_FIXED) begin
          st.cob[i][`CPE_VALID_BIT] <= 1'b1;
        end
      end
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign tx_valid_o = st.tx_valid;
  assign tx_id_o = st.tx_id;
  assign tx_len_o = st.tx_len;
  assign tx_data_o = st.tx_data;
  assign commit_o = st.commit;
  assign commit_map_o = st.commit_map;
  assign commit_data_o = st.commit_data;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_reject_op_write: assert property (ce_i && wr_i && operational_i && // R22
      addr_i[4:0] != `CPE_SUB_ERR |=> st.err == `CPE_ERR_STATE)
    else $error("write while operational not rejected");
  a_fixed_rx_id: assert property (ce_i && st.reload |=> // R6
      st.act_id[0] == `CPE_RX_BASE0 + {4'h0, $past(node_id_i)})
    else $error("fixed receive identifier wrong");
  a_fixed_tx_id: assert property (ce_i && st.reload |=> // R7
      st.act_id[11] == `CPE_TX_BASE3 + {4'h0, $past(node_id_i)})
    else $error("fixed transmit identifier wrong");
  a_id_not_live: assert property (ce_i && !st.reload && !comm_restart_i |=> // R5
      st.act_id == $past(st.act_id))
    else $error("identifier changed without restart");
  a_frame_held: assert property (ce_i && tx_valid_o && !tx_ready_i |=> // R2
      tx_valid_o && tx_data_o == $past(tx_data_o) && tx_len_o <= 4'h8)
    else $error("pending frame dropped or changed");
  a_only_operational: assert property (ce_i && !operational_i && // R1
      st.tx_fsm == cpe_pkg::cpe_tx_idle |=> !tx_valid_o)
    else $error("frame started outside operational");
  a_invalid_silent: assert property ($rose(tx_valid_o) |-> // R24
      !$past(st.cob[8 + st.tx_sel][`CPE_VALID_BIT]))
    else $error("invalid mapping transmitted");
  a_count_zero: assert property ($rose(tx_valid_o) |-> // R10
      $past(st.cnt[8 + st.tx_sel]) != 4'h0)
    else $error("disabled mapping transmitted");
  a_inhibit_load: assert property (ce_i && tx_valid_o && tx_ready_i && // R19
      st.ttype[8 + st.tx_sel] >= `CPE_TT_ASYNC_LO |=>
      st.inh_cnt[$past(st.tx_sel)] == st.inhibit[8 + $past(st.tx_sel)])
    else $error("inhibit time not armed");
  a_commit_rx_on: assert property (commit_o |-> $past(st.rx_commit_pend) != 8'h00) // R9
    else $error("commit without pending payload");

endmodule

// *** verification/cpe_can_master.sv ***
// behavioural network master: sync, receive frames, remote requests, frame sink
`timescale 1ns/1ps
module cpe_can_master (
  input  wire logic        mclk_i,
  output logic             sync_o,
  output logic             rx_valid_o,
  output logic      [10:0] rx_id_o,
  output logic             rx_rtr_o,
  output logic      [63:0] rx_data_o,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire logic [10:0] tx_id_i,
  input  wire logic [3:0]  tx_len_i,
  input  wire logic [63:0] tx_data_i
);
  int          ready_wait = 0;
  int          wait_cnt   = 0;
  int          cyc        = 0;
  int          got_n      = 0;
  int          got_time   = 0;
  logic [10:0] got_id     = 11'h000;
  logic [3:0]  got_len    = 4'h0;
  logic [63:0] got_data   = 64'h0;

  initial begin
    sync_o     = 1'b0;
    rx_valid_o = 1'b0;
    rx_id_o    = 11'h000;
    rx_rtr_o   = 1'b0;
    rx_data_o  = 64'h0;
    tx_ready_o = 1'b0;
  end

  // one frame per call; identifier and data lines show inverted leftovers once released
  task automatic send_frame(input logic [10:0] id, input logic rtr, input logic [63:0] d);
    @(posedge mclk_i);
    rx_valid_o <= 1'b1;
    rx_id_o    <= id;
    rx_rtr_o   <= rtr;
    rx_data_o  <= d;
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_id_o    <= ~id;
    rx_data_o  <= ~d;
  endtask

  task automatic send_sync();
    @(posedge mclk_i);
    sync_o <= 1'b1;
    @(posedge mclk_i);
    sync_o <= 1'b0;
  endtask

  // sink: ready after ready_wait cycles, dropped right after acceptance
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (tx_ready_o && tx_valid_i) begin
      got_id     = tx_id_i;
      got_len    = tx_len_i;
      got_data   = tx_data_i;
      got_time   = cyc;
      got_n      = got_n + 1;
      wait_cnt   = 0;
      tx_ready_o <= 1'b0;
    end else if (tx_valid_i && !tx_ready_o) begin
      if (wait_cnt >= ready_wait) begin
        tx_ready_o <= 1'b1;
      end else begin
        wait_cnt = wait_cnt + 1;
      end
    end
  end
endmodule

// *** verification/tb_cpe_pdo_engine.sv ***
// self-checking bench for the process data object engine
`timescale 1ns/1ps
`include "cpe_cfg.svh"
module tb_cpe_pdo_engine;
  localparam logic [6:0] NODE = 7'h05;
  logic          mclk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic [8:0]    addr_i = 9'h000;
  logic [31:0]   wdata_i = 32'h0;
  logic          wr_i = 1'b0;
  logic          rd_i = 1'b0;
  logic [31:0]   rdata_o;
  logic          operational_i = 1'b0;
  logic          comm_restart_i = 1'b0;
  logic          sync, rx_valid, rx_rtr, tx_valid_o, tx_ready, commit_o;
  logic [10:0]   rx_id, tx_id_o;
  logic [63:0]   rx_data, tx_data_o, commit_data_o, cm_data;
  logic [3:0]    tx_len_o;
  logic [2:0]    commit_map_o, cm_map;
  logic [511:0]  tx_obj = 512'h0;
  int            fail_count = 0;
  int            checks_done = 0;
  int            cm_n = 0;
  int            n0, t1, i, cyc = 0;

  always #4 mclk_i = ~mclk_i;

  cpe_pdo_engine #(.MS_CYCLES(8)) i_cpe_pdo_engine (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .node_id_i(NODE),
    .operational_i(operational_i), .comm_restart_i(comm_restart_i), .sync_i(sync),
    .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_rtr_i(rx_rtr), .rx_data_i(rx_data),
    .tx_obj_i(tx_obj), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready), .tx_id_o(tx_id_o),
    .tx_len_o(tx_len_o), .tx_data_o(tx_data_o), .commit_o(commit_o),
    .commit_map_o(commit_map_o), .commit_data_o(commit_data_o));

  cpe_can_master i_cpe_can_master (
    .mclk_i(mclk_i), .sync_o(sync), .rx_valid_o(rx_valid), .rx_id_o(rx_id),
    .rx_rtr_o(rx_rtr), .rx_data_o(rx_data), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready),
    .tx_id_i(tx_id_o), .tx_len_i(tx_len_o), .tx_data_i(tx_data_o));

  function automatic logic [8:0] ad(input logic tx, input int m, input logic [4:0] sub);
    return {tx, 3'(m), sub};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // read data sampled just after the edge that loads it
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  task automatic wait_tx(input int n);
    for (int k = 0; k < 300 && i_cpe_can_master.got_n < n; k++) @(posedge mclk_i);
    chk(64'(i_cpe_can_master.got_n), 64'(n));
  endtask

  task automatic set_op(input logic v);
    @(posedge mclk_i);
    operational_i <= v;
  endtask

  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // commit monitor; pulse lasts one cycle so every edge is looked at
  always @(posedge mclk_i) begin
    cyc++;
    if (commit_o === 1'b1) begin
      cm_n++;
      cm_map  = commit_map_o;
      cm_data = commit_data_o;
    end
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    // fixed identifiers and reset values
    for (i = 0; i < 4; i++) begin
      rd_chk(ad(0, i, `CPE_SUB_COB), 32'h200 + 32'(i) * 32'h100 + 32'(NODE));
      rd_chk(ad(1, i, `CPE_SUB_COB), 32'h180 + 32'(i) * 32'h100 + 32'(NODE));
    end
    rd_chk(ad(0, 4, `CPE_SUB_COB), 32'h8000_0000);
    rd_chk(ad(0, 0, `CPE_SUB_TYPE), 32'h0000_00FF);
    wr(ad(0, 0, `CPE_SUB_COB), 32'h0000_0123);
    rd_chk(ad(0, 0, `CPE_SUB_COB), 32'h0000_0205);
    // entry packing limit: 16 + 32 fits, adding 48 overflows
    wr(ad(0, 0, `CPE_SUB_ENT0), 32'h6040_0010);
    wr(ad(0, 0, `CPE_SUB_ENT0 + 5'h01), 32'h607A_0020);
    wr(ad(0, 0, `CPE_SUB_ENT0 + 5'h02), 32'h6060_0030);
    wr(ad(0, 0, `CPE_SUB_CNT), 32'h0000_0002);
    rd_chk(ad(0, 0, `CPE_SUB_ERR), 32'h0);
    wr(ad(0, 0, `CPE_SUB_CNT), 32'h0000_0003);
    rd_chk(ad(0, 0, `CPE_SUB_ERR), `CPE_ERR_OVF);
    rd_chk(ad(0, 0, `CPE_SUB_CNT), 32'h0000_0002);
    wr(ad(0, 0, `CPE_SUB_ERR), 32'h0);
    // configuration only while not operational
    wr(ad(0, 1, `CPE_SUB_TYPE), 32'h0000_0001);
    wr(ad(0, 1, `CPE_SUB_ENT0), 32'h6042_0020);
    wr(ad(0, 1, `CPE_SUB_CNT), 32'h0000_0001);
    wr(ad(0, 4, `CPE_SUB_COB), 32'h0000_0234);
    wr(ad(0, 4, `CPE_SUB_ENT0), 32'h60FE_0108);
    wr(ad(0, 4, `CPE_SUB_CNT), 32'h0000_0001);
    wr(ad(1, 0, `CPE_SUB_TYPE), 32'h0000_0001);
    wr(ad(1, 0, `CPE_SUB_ENT0), 32'h6041_0010);
    wr(ad(1, 0, `CPE_SUB_CNT), 32'h0000_0001);
    wr(ad(1, 1, `CPE_SUB_TYPE), 32'h0000_00FE);
    wr(ad(1, 1, `CPE_SUB_INH), 32'h0000_0002);
    wr(ad(1, 1, `CPE_SUB_ENT0), 32'h6064_0020);
    wr(ad(1, 1, `CPE_SUB_CNT), 32'h0000_0001);
    tx_obj[15:0]  <= 16'hA55A;
    tx_obj[95:64] <= 32'h1234_5678;
    // entering operational raises an event for the asynchronous mapping
    set_op(1'b1);
    wait_tx(1);
    chk({i_cpe_can_master.got_id, i_cpe_can_master.got_len}, {11'h285, 4'h4});
    chk(i_cpe_can_master.got_data, 64'h1234_5678);
    t1 = i_cpe_can_master.got_time;
    tx_obj[95:64] <= 32'h0BAD_F00D;
    wait_tx(2);
    chk(64'(i_cpe_can_master.got_time - t1 >= 8), 64'h1);
    wr(ad(0, 1, `CPE_SUB_TYPE), 32'h0000_00FE);
    rd_chk(ad(0, 0, `CPE_SUB_ERR), `CPE_ERR_STATE);
    rd_chk(ad(0, 1, `CPE_SUB_TYPE), 32'h0000_0001);
    // asynchronous receive commits at once
    i_cpe_can_master.send_frame(11'h205, 1'b0, 64'hC0DE_0000_0000_BEEF);
    repeat (3) @(posedge mclk_i);
    chk({61'h0, cm_map}, 64'h0);
    chk(cm_data, 64'hC0DE_0000_0000_BEEF);
    // synchronous receive waits for sync; sync also sends tx type 1, slow sink
    n0 = cm_n;
    i_cpe_can_master.send_frame(11'h305, 1'b0, 64'h0000_0000_7777_1111);
    repeat (4) @(posedge mclk_i);
    chk(64'(cm_n), 64'(n0));
    i_cpe_can_master.ready_wait = 4;
    i_cpe_can_master.send_sync();
    repeat (3) @(posedge mclk_i);
    chk({61'h0, cm_map}, 64'h1);
    chk(cm_data, 64'h0000_0000_7777_1111);
    wait_tx(3);
    chk({i_cpe_can_master.got_id, i_cpe_can_master.got_len}, {11'h185, 4'h2});
    chk(i_cpe_can_master.got_data, 64'hA55A);
    // new identifier before restart is not active yet
    n0 = cm_n;
    i_cpe_can_master.send_frame(11'h234, 1'b0, 64'h42);
    repeat (3) @(posedge mclk_i);
    chk(64'(cm_n), 64'(n0));
    set_op(1'b0);
    wr(ad(0, 0, `CPE_SUB_COB), 32'h8000_0000);
    @(posedge mclk_i) comm_restart_i <= 1'b1;
    @(posedge mclk_i) comm_restart_i <= 1'b0;
    i_cpe_can_master.send_frame(11'h234, 1'b0, 64'h43);
    repeat (3) @(posedge mclk_i);
    chk(64'(cm_n), 64'(n0));
    set_op(1'b1);
    i_cpe_can_master.send_frame(11'h205, 1'b0, 64'h44);
    repeat (3) @(posedge mclk_i);
    chk(64'(cm_n), 64'(n0));
    i_cpe_can_master.send_frame(11'h234, 1'b0, 64'h45);
    repeat (3) @(posedge mclk_i);
    chk({61'h0, cm_map}, 64'h4);
    chk(cm_data, 64'h45);
    repeat (20) @(posedge mclk_i);
    end_sim();
  end
endmodule
